// ==== logic/iod_decode.v ====
// top of the indexed offset address decoder: instruction decode for the
// pointer subtract and return group, operand address steering, registers
// assumes fetch, return stack and data memory on the same clock outside
//
// Summary of operation
// RULE1: opcode e9 with select 11 subtracts 6-bit literal from frame pointer, flags kept
// RULE2: after that subtraction the pc is loaded from the return stack top
// RULE3: that instruction takes two cycles, the second one does nothing
// RULE4: select value 3 always targets the frame pointer and adds the return
// RULE5: extension enable also turns on indexed offsets and extra opcodes
// RULE6: extension off: a=0 means access bank, a=1 the bank select register
// RULE7: extension on, a=0, operand up to 5fh: address is frame pointer plus offset
// RULE8: indexed meaning holds for every byte and bit operation with access bit
// RULE9: frame pointer zero makes indexed addresses equal the plain access ram
// RULE10: indexed form has access bit 0 and offset in the file field
// RULE11: destination bit keeps its meaning: 0 to w, else back to register
// RULE12: opcode e9 subtracts 6-bit literal from selected pointer in one cycle
// RULE13: extension enable bit clear disables extra opcodes and indexing
// RULE14: extension on, operands above 5fh or with a=1 stay literal
//
// Added by the designer: the AXI4-Lite register port and the register offsets.

`timescale 1ns/1ns
`include "iod_regs.vh"
module iod_decode (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clk_en,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        instr_valid,
    output wire        instr_ready,
    input  wire [15:0] instr_word,
    input  wire [20:0] top_of_return_stack,
    output reg         op_valid_r,
    output reg         has_file_r,
    output reg  [11:0] data_addr_r,
    output reg         addr_indexed_r,
    output reg         dest_to_w_r,
    output reg         ptr_sub_valid_r,
    output reg  [1:0]  ptr_sub_sel_r,
    output reg  [5:0]  ptr_sub_lit_r,
    output reg         pc_load_r,
    output reg  [20:0] pc_value_r,
    output reg         ext_op_r,
    output reg         ext_illegal_r,
    output wire [11:0] stack_frame_pointer
);
    // sequencer states
    localparam ST_RUN = 1'b0;
    localparam ST_NOP = 1'b1;

    // sequencer and software state
    reg         state_r;
    reg         state_nxt;
    reg         ext_en_r;
    reg  [11:0] fp_r;
    reg  [11:0] fp_nxt;
    reg  [31:0] fp_wr_word;
    reg  [3:0]  bank_r;
    reg  [11:0] last_ea_r;
    reg         last_idx_r;
    reg         last_ill_r;
    reg  [7:0]  ret_cnt_r;

    // slave register port
    wire        wr_en;
    wire [7:0]  wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    reg         wr_ok;
    reg  [31:0] rd_data;
    reg         rd_ok;

    // address generator outputs
    wire        ag_has_file;
    wire        ag_indexed;
    wire        ag_dest_w;
    wire [11:0] ag_eff_addr;

    // opcode decode strobes
    wire        take;
    wire        is_ptrsub;
    wire        is_movidx;
    wire [1:0]  sub_sel;
    wire [5:0]  sub_lit;
    wire        ext_ok;
    wire        do_ret;
    wire        fp_sub;

    // merge written bytes into an old register value
    function [31:0] lane_merge;
        input [31:0] old;
        input [31:0] din;
        input [3:0]  strb;
        integer      i;
        begin
            lane_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i])
                    lane_merge[i*8 +: 8] = din[i*8 +: 8];
            end
        end
    endfunction

    // true when an address matches a mapped register
    function reg_hit;
        input [7:0] a;
        begin
            case (a)
                `IOD_OFS_CTRL, `IOD_OFS_FPTR, `IOD_OFS_BANK,
                `IOD_OFS_STATUS, `IOD_OFS_RETCNT: reg_hit = 1'b1;
                default: reg_hit = 1'b0;
            endcase
        end
    endfunction

    // bus slave: handshakes and response timing
    iod_axil_slave u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .clk_en        (clk_en),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr_r     (wr_addr),
        .wr_data_r     (wr_data),
        .wr_strb_r     (wr_strb),
        .wr_ok         (wr_ok),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    // operand address from current pointer, bank and extension mode
    iod_addr_gen u_addr (
        .instr_word (instr_word),
        .ext_en     (ext_en_r),
        .frame_ptr  (fp_r),
        .bank_sel   (bank_r),
        .has_file   (ag_has_file),
        .indexed    (ag_indexed),
        .dest_w     (ag_dest_w),
        .eff_addr   (ag_eff_addr)
    );

    // RULE3: no fetch in the second cycle
    assign instr_ready = clk_en & (state_r == ST_RUN);
    assign take        = instr_valid & instr_ready;

    // opcode fields of the pointer subtract group
    assign is_ptrsub = (instr_word[15:8] == `IOD_OP_PTRSUB);
    assign is_movidx = (instr_word[15:8] == `IOD_OP_MOVIDX);
    assign sub_sel   = instr_word[7:6];
    assign sub_lit   = instr_word[5:0];

    // RULE13: extra opcodes need the enable
    assign ext_ok = ext_en_r;
    // RULE4: select 3 means return
    assign do_ret = take & is_ptrsub & ext_ok & (sub_sel == `IOD_SEL_RET);
    // RULE1: frame pointer for select 2 or 3
    assign fp_sub = take & is_ptrsub & ext_ok
                  & ((sub_sel == `IOD_SEL_FP) | (sub_sel == `IOD_SEL_RET));

    assign stack_frame_pointer = fp_r;

    // sequencer: a return instruction holds off fetch for one cycle
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (do_ret)
                    state_nxt = ST_NOP;
            end
            ST_NOP: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // next frame pointer: instruction subtract takes priority over software
    always @* begin
        fp_nxt = fp_r;
        fp_wr_word = lane_merge({20'h0_0000, fp_r}, wr_data, wr_strb);
        if (fp_sub)
            fp_nxt = fp_r - {6'h00, sub_lit};
        else if (wr_en && wr_addr == `IOD_OFS_FPTR)
            fp_nxt = fp_wr_word[11:0];
    end

    // write decode answer for the slave
    always @* begin
        wr_ok = reg_hit(wr_addr);
    end

    // read mux: narrow fields in the low bits, upper bits read zero
    always @* begin
        rd_ok   = reg_hit(s_axi_araddr);
        rd_data = 32'h0000_0000;
        case (s_axi_araddr)
            `IOD_OFS_CTRL:   rd_data[`IOD_CTRL_EXT] = ext_en_r;
            `IOD_OFS_FPTR:   rd_data[11:0] = fp_r;
            `IOD_OFS_BANK:   rd_data[3:0] = bank_r;
            `IOD_OFS_STATUS: begin
                rd_data[`IOD_ST_EA_LSB +: 12] = last_ea_r;
                rd_data[`IOD_ST_IDX]          = last_idx_r;
                rd_data[`IOD_ST_NOP]          = state_r;
                rd_data[`IOD_ST_ILL]          = last_ill_r;
            end
            `IOD_OFS_RETCNT: rd_data[7:0] = ret_cnt_r;
            default:         rd_data = 32'h0000_0000;
        endcase
    end

    // software registers and the frame pointer
    always @(posedge aclk) begin
        if (!aresetn) begin
            ext_en_r <= `IOD_CTRL_RST;
            fp_r     <= `IOD_FPTR_RST;
            bank_r   <= `IOD_BANK_RST;
        end else if (clk_en) begin
            // RULE5: one bit enables both
            if (wr_en && wr_addr == `IOD_OFS_CTRL && wr_strb[0])
                ext_en_r <= wr_data[`IOD_CTRL_EXT];
            if (wr_en && wr_addr == `IOD_OFS_BANK && wr_strb[0])
                bank_r <= wr_data[3:0];

            // RULE12: pointer written in first cycle
            fp_r <= fp_nxt;
        end
    end

    // sequencer state and return counter
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r   <= ST_RUN;
            ret_cnt_r <= 8'h00;
        end else if (clk_en) begin
            state_r <= state_nxt;

            // return count: instruction wins over a clearing write
            if (do_ret)
                ret_cnt_r <= ret_cnt_r + 8'h01;
            else if (wr_en && wr_addr == `IOD_OFS_RETCNT)
                ret_cnt_r <= 8'h00;
        end
    end

    // decode results, one cycle after the word is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            op_valid_r      <= 1'b0;
            has_file_r      <= 1'b0;
            data_addr_r     <= 12'h000;
            addr_indexed_r  <= 1'b0;
            dest_to_w_r     <= 1'b0;
            ptr_sub_valid_r <= 1'b0;
            ptr_sub_sel_r   <= 2'h0;
            ptr_sub_lit_r   <= 6'h00;
            pc_load_r       <= 1'b0;
            pc_value_r      <= 21'h00_0000;
            ext_op_r        <= 1'b0;
            ext_illegal_r   <= 1'b0;
        end else if (clk_en) begin
            op_valid_r      <= take;
            ptr_sub_valid_r <= 1'b0;
            pc_load_r       <= 1'b0;
            ext_op_r        <= 1'b0;
            ext_illegal_r   <= 1'b0;

            if (take) begin
                // RULE9: fp zero gives plain access
                has_file_r     <= ag_has_file;
                data_addr_r    <= ag_eff_addr;
                // RULE14: others stay literal
                addr_indexed_r <= ag_indexed;
                // RULE11: destination select
                dest_to_w_r    <= ag_dest_w;
                ext_op_r       <= ext_ok & (is_ptrsub | is_movidx);
                ext_illegal_r  <= ~ext_ok & (is_ptrsub | is_movidx);
                // RULE12: selects 0 to 3 all handed out
                if (is_ptrsub && ext_ok) begin
                    ptr_sub_valid_r <= 1'b1;
                    ptr_sub_sel_r   <= sub_sel;
                    ptr_sub_lit_r   <= sub_lit;
                end
                // RULE2: return to stack top
                if (do_ret) begin
                    pc_load_r  <= 1'b1;
                    pc_value_r <= top_of_return_stack;
                end
            end
        end
    end

    // status capture of the last operand decode
    always @(posedge aclk) begin
        if (!aresetn) begin
            last_ea_r  <= 12'h000;
            last_idx_r <= 1'b0;
            last_ill_r <= 1'b0;
        end else if (clk_en && take) begin
            if (ag_has_file) begin
                last_ea_r  <= ag_eff_addr;
                last_idx_r <= ag_indexed;
            end
            if (is_ptrsub | is_movidx)
                last_ill_r <= ~ext_ok;
        end
    end
endmodule // iod_decode

// ==== logic/iod_regs.vh ====
// register map, field positions, reset values and opcode constants
// of the indexed offset address decoder; included by its design files
`ifndef IOD_REGS_VH
`define IOD_REGS_VH

// register byte offsets on the axi4-lite bus
`define IOD_OFS_CTRL    8'h00
`define IOD_OFS_FPTR    8'h04
`define IOD_OFS_BANK    8'h08
`define IOD_OFS_STATUS  8'h0c
`define IOD_OFS_RETCNT  8'h10

// ctrl field: extension enable, off after reset
`define IOD_CTRL_EXT    0
`define IOD_CTRL_RST    1'b0

// reset values of pointer and bank select
`define IOD_FPTR_RST    12'h000
`define IOD_BANK_RST    4'h0

// status fields
`define IOD_ST_EA_LSB   0
`define IOD_ST_IDX      12
`define IOD_ST_NOP      13
`define IOD_ST_ILL      14

// axi responses
`define IOD_RESP_OKAY   2'h0
`define IOD_RESP_SLVERR 2'h2

// opcodes and fields
`define IOD_OP_PTRSUB   8'he9
`define IOD_OP_MOVIDX   8'heb
`define IOD_SEL_FP      2'h2
`define IOD_SEL_RET     2'h3
`define IOD_IDX_LIMIT   8'h5f
`define IOD_SFR_PAGE    4'hf
`define IOD_RET_CYCLES  2

`endif

// ==== logic/iod_axil_slave.v ====
// axi4-lite slave front end of the decoder register file
// assumes the same clock as the decoder; register decode sits in the parent
`timescale 1ns/1ns
`include "iod_regs.vh"
module iod_axil_slave (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clk_en,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        wr_en,
    output reg  [7:0]  wr_addr_r,
    output reg  [31:0] wr_data_r,
    output reg  [3:0]  wr_strb_r,
    input  wire        wr_ok,
    input  wire [31:0] rd_data,
    input  wire        rd_ok
);
    reg aw_full_r;
    reg w_full_r;

    // address and data are held separately, so they may come in either order
    assign s_axi_awready = clk_en & ~aw_full_r;
    assign s_axi_wready  = clk_en & ~w_full_r;
    assign wr_en         = clk_en & aw_full_r & w_full_r & ~s_axi_bvalid;
    assign s_axi_arready = clk_en & ~s_axi_rvalid;

    // write channel capture and response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r    <= 1'b0;
            w_full_r     <= 1'b0;
            wr_addr_r    <= 8'h00;
            wr_data_r    <= 32'h0000_0000;
            wr_strb_r    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `IOD_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && !aw_full_r) begin
                aw_full_r <= 1'b1;
                wr_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_r) begin
                w_full_r  <= 1'b1;
                wr_data_r <= s_axi_wdata;
                wr_strb_r <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `IOD_RESP_OKAY : `IOD_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: data registered one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `IOD_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
                s_axi_rresp  <= rd_ok ? `IOD_RESP_OKAY : `IOD_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // iod_axil_slave

// ==== logic/iod_addr_gen.v ====
// combinational data address generator for file register operands
// assumes a 16-bit instruction word and a 12-bit data space
`timescale 1ns/1ns
`include "iod_regs.vh"
module iod_addr_gen (
    input  wire [15:0] instr_word,
    input  wire        ext_en,
    input  wire [11:0] frame_ptr,
    input  wire [3:0]  bank_sel,
    output wire        has_file,
    output wire        indexed,
    output wire        dest_w,
    output wire [11:0] eff_addr
);
    // byte and bit operations carrying the access select bit
    function has_access;
        input [15:0] op;
        begin
            case (op[15:12])
                4'h0:    has_access = (op[11:9] != 3'h0);
                4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                4'h8, 4'h9, 4'ha, 4'hb: has_access = 1'b1;
                default: has_access = 1'b0;
            endcase
        end
    endfunction

    // byte operations with a destination select bit
    function has_dest;
        input [15:0] op;
        begin
            if (op[15:12] == 4'h0)
                has_dest = (op[11:10] == 2'b01);
            else
                has_dest = (op[15:12] <= 4'h5);
        end
    endfunction

    // RULE7: frame pointer offset
    function [11:0] calc_addr;
        input [7:0]  f;
        input        idx;
        input        acc;
        input [11:0] fp;
        input [3:0]  bank;
        begin
            if (idx)
                calc_addr = fp + {4'h0, f};
            else if (acc)
                calc_addr = {bank, f};
            else if (f <= `IOD_IDX_LIMIT)
                calc_addr = {4'h0, f};
            else
                calc_addr = {`IOD_SFR_PAGE, f};
        end
    endfunction

    // RULE8: all access-bit operations
    assign has_file = has_access(instr_word);
    // RULE10: indexed only with a=0
    assign indexed  = has_file & ext_en & ~instr_word[8]
                    & (instr_word[7:0] <= `IOD_IDX_LIMIT);
    // RULE11: d=0 sends result to w
    assign dest_w   = has_dest(instr_word) & ~instr_word[9];
    // RULE6: literal access or bank
    assign eff_addr = calc_addr(instr_word[7:0], indexed, instr_word[8],
                                frame_ptr, bank_sel);
endmodule // iod_addr_gen

// ==== tb/iod_decode_checker.sv ====
// concurrent checks on the decoder top ports
// assumes a bind to iod_decode, one clock domain, clk_en held high
`timescale 1ns/1ns
module iod_decode_checker (
    input logic        aclk,
    input logic        aresetn,
    input logic        instr_ready,
    input logic [15:0] instr_word,
    input logic [20:0] top_of_return_stack,
    input logic        op_valid_r,
    input logic        has_file_r,
    input logic [11:0] data_addr_r,
    input logic        addr_indexed_r,
    input logic        dest_to_w_r,
    input logic        ptr_sub_valid_r,
    input logic [1:0]  ptr_sub_sel_r,
    input logic [5:0]  ptr_sub_lit_r,
    input logic        pc_load_r,
    input logic [20:0] pc_value_r,
    input logic        ext_op_r,
    input logic        ext_illegal_r,
    input logic [11:0] stack_frame_pointer
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // return decode seen, then its dead slot
    sequence s_ret_take;
        ptr_sub_valid_r && ptr_sub_sel_r == 2'h3;
    endsequence
    sequence s_nop_slot;
        !instr_ready ##1 instr_ready;
    endsequence
    a_ret_pc_load: assert property (s_ret_take |-> pc_load_r
        && pc_value_r == $past(top_of_return_stack)) else $error("return lost pc");
    a_ret_nop_slot: assert property (pc_load_r |-> s_nop_slot)
        else $error("return slot wrong");
    a_ret_select: assert property (pc_load_r |-> s_ret_take)
        else $error("pc load without return");
    a_sub_frame: assert property (ptr_sub_valid_r && ptr_sub_sel_r[1] |->
        stack_frame_pointer == $past(stack_frame_pointer) - {6'h0, ptr_sub_lit_r})
        else $error("frame pointer subtract wrong");
    a_sub_one_cycle: assert property (ptr_sub_valid_r && ptr_sub_sel_r != 2'h3 |->
        !pc_load_r && instr_ready) else $error("subtract not single cycle");
    a_ext_gate: assert property (ext_illegal_r |-> !ext_op_r && !ptr_sub_valid_r
        && $stable(stack_frame_pointer)) else $error("disabled opcode acted");
    a_idx_addr: assert property (op_valid_r && addr_indexed_r |->
        !$past(instr_word[8]) && $past(instr_word[7:0]) <= 8'h5f
        && data_addr_r == $past(stack_frame_pointer) + {4'h0, $past(instr_word[7:0])})
        else $error("indexed address wrong");
    a_lit_addr: assert property (op_valid_r && has_file_r && !addr_indexed_r |->
        data_addr_r[7:0] == $past(instr_word[7:0])) else $error("literal address wrong");
    a_dest_bit: assert property (op_valid_r && $past(instr_word[15:12]) == 4'h2 |->
        dest_to_w_r == !$past(instr_word[9])) else $error("destination bit wrong");
endmodule // iod_decode_checker

bind iod_decode iod_decode_checker u_iod_decode_checker (.aclk, .aresetn, .instr_ready,
    .instr_word, .top_of_return_stack, .op_valid_r, .has_file_r, .data_addr_r,
    .addr_indexed_r, .dest_to_w_r, .ptr_sub_valid_r, .ptr_sub_sel_r, .ptr_sub_lit_r,
    .pc_load_r, .pc_value_r, .ext_op_r, .ext_illegal_r, .stack_frame_pointer);

// ==== tb/iod_decode_tb.sv ====
// self-checking bench: axi4-lite register access and instruction decode
// assumes the decoder top alone; the bench drives every port itself
`timescale 1ns/1ns
`include "iod_regs.vh"
module iod_decode_tb;
    logic        aclk, aresetn, clk_en, instr_valid, instr_ready;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, ptr_sub_sel_r, rresp;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb;
    logic [15:0] instr_word;
    logic [20:0] top_of_return_stack, pc_value_r;
    logic        op_valid_r, has_file_r, addr_indexed_r, dest_to_w_r, ptr_sub_valid_r;
    logic        pc_load_r, ext_op_r, ext_illegal_r;
    logic [11:0] data_addr_r, stack_frame_pointer;
    logic [5:0]  ptr_sub_lit_r;
    int          errors, check_count, waits;
    bit          held;

    iod_decode u_iod_decode (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .instr_valid, .instr_ready, .instr_word, .top_of_return_stack, .op_valid_r,
        .has_file_r, .data_addr_r, .addr_indexed_r, .dest_to_w_r, .ptr_sub_valid_r,
        .ptr_sub_sel_r, .ptr_sub_lit_r, .pc_load_r, .pc_value_r, .ext_op_r,
        .ext_illegal_r, .stack_frame_pointer);

    // 100 mhz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task conclude();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // axi write: address and data offered together, each released when taken
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw, w;
        aw = 0;
        w = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        rd(a, rdat, rresp);
        chk(rdat, e);
        chk(32'(rresp), 32'(er));
    endtask

    task wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        wr(a, d, rresp);
        chk(32'(rresp), 32'(er));
    endtask

    // offer one word; keep leaves valid up for a back-to-back word
    task iss(input logic [15:0] w, input bit keep);
        if (!held) @(posedge aclk);
        instr_word <= w;
        instr_valid <= 1'b1;
        waits = 0;
        do begin
            @(posedge aclk);
            waits++;
        end while (instr_ready !== 1'b1);
        if (!keep) instr_valid <= 1'b0;
        held = keep;
        #1;
    endtask

    task dec(input logic [15:0] w, input logic [11:0] ea, input logic ix,
             input logic dw);
        iss(w, 1'b0);
        chk(32'({op_valid_r, has_file_r, addr_indexed_r, dest_to_w_r, data_addr_r}),
            32'({1'b1, 1'b1, ix, dw, ea}));
    endtask

    // watchdog
    initial begin
        #100000;
        errors++;
        conclude();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, instr_valid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {instr_word, top_of_return_stack, held} = '0;
        clk_en = 1'b1;
        s_axi_wstrb = 4'hf;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`IOD_OFS_CTRL, 32'h0, `IOD_RESP_OKAY);
        wchk(`IOD_OFS_FPTR, 32'h3ff, `IOD_RESP_OKAY);
        wchk(`IOD_OFS_BANK, 32'h5, `IOD_RESP_OKAY);
        rchk(`IOD_OFS_FPTR, 32'h3ff, `IOD_RESP_OKAY);
        rchk(8'h40, 32'h0, `IOD_RESP_SLVERR);
        wchk(8'h44, 32'h1, `IOD_RESP_SLVERR);
        $display("registers done");
        dec(16'h2420, 12'h020, 1'b0, 1'b1);
        dec(16'h2480, 12'hf80, 1'b0, 1'b1);
        dec(16'h2730, 12'h530, 1'b0, 1'b0);
        iss(16'he9c5, 1'b0);
        chk(32'({ext_illegal_r, ext_op_r, ptr_sub_valid_r, pc_load_r}), 32'h8);
        chk(32'(stack_frame_pointer), 32'h3ff);
        $display("extension off done");
        wchk(`IOD_OFS_CTRL, 32'h1, `IOD_RESP_OKAY);
        dec(16'h2420, 12'h41f, 1'b1, 1'b1);
        dec(16'h245f, 12'h45e, 1'b1, 1'b1);
        dec(16'h2460, 12'hf60, 1'b0, 1'b1);
        dec(16'h2520, 12'h520, 1'b0, 1'b1);
        dec(16'h2620, 12'h41f, 1'b1, 1'b0);
        dec(16'h8e10, 12'h40f, 1'b1, 1'b0);
        rd(`IOD_OFS_STATUS, rdat, rresp);
        chk(rdat & 32'h7fff, 32'h540f);
        $display("indexed operands done");
        for (int s = 0; s < 3; s++) begin
            iss({8'he9, s[1:0], 6'h03}, 1'b0);
            chk(32'({ptr_sub_valid_r, ext_op_r, pc_load_r, instr_ready, ptr_sub_sel_r,
                ptr_sub_lit_r}), 32'({4'hd, s[1:0], 6'h03}));
            chk(32'(stack_frame_pointer), (s == 2) ? 32'h3fc : 32'h3ff);
        end
        $display("pointer subtract done");
        top_of_return_stack <= 21'h1abcd;
        iss(16'he9c5, 1'b1);
        chk(32'({pc_load_r, pc_value_r, instr_ready}), 32'({1'b1, 21'h1abcd, 1'b0}));
        chk(32'({ptr_sub_valid_r, ptr_sub_sel_r, ptr_sub_lit_r}), 32'h1c5);
        chk(32'(stack_frame_pointer), 32'h3f7);
        iss(16'h2400, 1'b0);
        chk(32'(waits), 32'd2);
        chk(32'({op_valid_r, pc_load_r, data_addr_r}), 32'({2'b10, 12'h3f7}));
        rchk(`IOD_OFS_RETCNT, 32'h1, `IOD_RESP_OKAY);
        $display("return done");
        wchk(`IOD_OFS_FPTR, 32'h0, `IOD_RESP_OKAY);
        dec(16'h2430, 12'h030, 1'b1, 1'b1);
        $display("zero pointer done");
        conclude();
    end
endmodule // iod_decode_tb
